// ---- logic/rx_pkg.sv ----
// constants and types shared by the serial receiver files
package rx_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_CTRLB = 8'h08;
  localparam logic [7:0] ADDR_CTRLC = 8'h0C;
  localparam logic [7:0] ADDR_BAUD  = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int STAT_RXC   = 7;
  localparam int STAT_FE    = 4;
  localparam int STAT_PE    = 2;
  localparam int STAT_DS    = 1;
  localparam int CTRLB_EN   = 4;
  localparam int CTRLC_PM_H = 5;
  localparam int CTRLC_PM_L = 4;
  localparam int CTRLC_CS_H = 2;
  localparam int CTRLC_CS_L = 1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  CTRLC_RST = 8'h06;
  localparam logic [11:0] BAUD_RST  = 12'h000;

  // ----------------------------------------
  // sampling
  // ----------------------------------------
  localparam logic [4:0] SAMP_NORM = 5'h10;
  localparam logic [4:0] SAMP_DS   = 5'h08;
  localparam logic [4:0] VOTE_NORM = 5'h08;
  localparam logic [4:0] VOTE_DS   = 5'h04;
  localparam logic [4:0] VOTE_SPAN = 5'h02;
  localparam int         BUF_DEPTH = 2;
  localparam int         ENTRY_W   = 10;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_BITS  = 5'b00100,
    ST_PAR   = 5'b01000,
    ST_STOP  = 5'b10000
  } rx_state_e;

endpackage : rx_pkg

// ---- logic/rx_buffer.sv ----
// two-entry receive buffer holding data with its error flags
`timescale 1ns/1ps
`default_nettype none
module rx_buffer
  import rx_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               flush,
  input  wire logic               push,
  input  wire logic [ENTRY_W-1:0] push_data,
  input  wire logic               pop,
  output logic      [ENTRY_W-1:0] head,
  output logic                    not_empty
);
  import rx_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [ENTRY_W-1:0] mem_reg [BUF_DEPTH];
  logic [ENTRY_W-1:0] mem_next [BUF_DEPTH];
  logic               wr_reg, wr_next;
  logic               rd_reg, rd_next;
  logic [1:0]         cnt_reg, cnt_next;
  logic               do_push;
  logic               do_pop;

  // a full buffer drops the new character rather than stall the line
  assign do_push   = push && (cnt_reg != 2'(BUF_DEPTH));
  assign do_pop    = pop && (cnt_reg != 2'h0);
  assign head      = mem_reg[rd_reg];
  assign not_empty = (cnt_reg != 2'h0);

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_entry
      always_comb begin
        mem_next[gi] = mem_reg[gi];
        if (do_push && (wr_reg == 1'(gi))) begin
          mem_next[gi] = push_data;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mem_reg[gi] <= '0;
        end else begin
          mem_reg[gi] <= mem_next[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_next  = 1'b0;
      rd_next  = 1'b0;
      cnt_next = 2'h0;
    end else begin
      if (do_push) begin
        wr_next = ~wr_reg;
      end
      if (do_pop) begin
        rd_next = ~rd_reg;
      end
      cnt_next = cnt_reg + 2'(do_push) - 2'(do_pop);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : rx_buffer
`default_nettype wire

// ---- logic/serial_rx.sv ----
// asynchronous serial receiver with oversampled recovery and ahb-lite registers
// How it works
// - parity checked only when mode high bit set
// - mode low bit selects odd or even parity
// - parity outcome stored with data and stop
// - parity flag follows oldest unread character
// - disable aborts frame and releases pin
// - disable flushes every buffered character
// - sample at 16x, or 8x double speed
// - start checked at samples 8-10 or 4-6
// - majority high start is noise, rewait edge
// - valid start aligns bit phase each frame
// - sixteen or eight states per bit
// - each bit is majority of three centre samples
// - voting starts at sample 8 or 4
// - stop after first stop bit, ignore rest
// - zero first stop bit sets frame error
// - next start accepted right after stop vote at normal speed
// - parity flag reads zero when checking off
// - buffer holds two characters; a third finished while full is dropped
// - complete flag set while buffer holds data
// - enable takes over the receive pin
`timescale 1ns/1ps
`default_nettype none
module serial_rx
  import rx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_in_pin,
  output logic             serial_pin_owned
);
  import rx_pkg::*;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        double_speed_select_reg, double_speed_select_next;
  logic        receiver_enable_reg, receiver_enable_next;
  logic [7:0]  serial_control_c_reg, serial_control_c_next;
  logic [11:0] baud_div_reg, baud_div_next;
  logic        addr_ok;
  logic        rd_pop;
  logic [ENTRY_W-1:0] head;
  logic        head_valid;
  logic        rx_complete_flag;
  logic        parity_error_flag;
  logic        frame_error_flag;
  logic [7:0]  serial_status_a;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign addr_ok   = hsel && hready && htrans[1];
  assign rd_pop    = addr_ok && !hwrite && (haddr[7:0] == ADDR_DATA);
  assign serial_pin_owned  = receiver_enable_reg;
  assign rx_complete_flag  = head_valid;
  assign frame_error_flag  = rx_complete_flag && head[8];
  // checking switched off masks any stored parity error
  assign parity_error_flag = rx_complete_flag && head[9]
                             && serial_control_c_reg[CTRLC_PM_H];

  always_comb begin
    serial_status_a           = 8'h00;
    serial_status_a[STAT_RXC] = rx_complete_flag;
    serial_status_a[STAT_FE]  = frame_error_flag;
    serial_status_a[STAT_PE]  = parity_error_flag;
    serial_status_a[STAT_DS]  = double_speed_select_reg;
  end

  always_comb begin
    wr_pend_next             = addr_ok && hwrite;
    wr_addr_next             = haddr[7:0];
    rdata_next               = rdata_reg;
    double_speed_select_next = double_speed_select_reg;
    receiver_enable_next     = receiver_enable_reg;
    serial_control_c_next    = serial_control_c_reg;
    baud_div_next            = baud_div_reg;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_DATA:  rdata_next = {24'h000000, head[7:0]};
        ADDR_STAT:  rdata_next = {24'h000000, serial_status_a};
        ADDR_CTRLB: rdata_next = {27'h0000000, receiver_enable_reg, 4'h0};
        ADDR_CTRLC: rdata_next = {24'h000000, serial_control_c_reg};
        ADDR_BAUD:  rdata_next = {20'h00000, baud_div_reg};
        default:    rdata_next = 32'h00000000;
      endcase
    end
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        ADDR_STAT:  double_speed_select_next = hwdata[STAT_DS];
        ADDR_CTRLB: receiver_enable_next     = hwdata[CTRLB_EN];
        ADDR_CTRLC: serial_control_c_next    = hwdata[7:0];
        ADDR_BAUD:  baud_div_next            = hwdata[11:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg             <= 1'b0;
      wr_addr_reg             <= 8'h00;
      rdata_reg               <= 32'h00000000;
      double_speed_select_reg <= 1'b0;
      receiver_enable_reg     <= 1'b0;
      serial_control_c_reg    <= CTRLC_RST;
      baud_div_reg            <= BAUD_RST;
    end else begin
      wr_pend_reg             <= wr_pend_next;
      wr_addr_reg             <= wr_addr_next;
      rdata_reg               <= rdata_next;
      double_speed_select_reg <= double_speed_select_next;
      receiver_enable_reg     <= receiver_enable_next;
      serial_control_c_reg    <= serial_control_c_next;
      baud_div_reg            <= baud_div_next;
    end
  end

  // ----------------------------------------
  // sample tick
  // ----------------------------------------
  logic [11:0] div_reg, div_next;
  logic        tick;

  assign tick = (div_reg == 12'h000);

  always_comb begin
    div_next = tick ? baud_div_reg : div_reg - 12'h001;
    if (!receiver_enable_reg) begin
      div_next = baud_div_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= BAUD_RST;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------
  // clock and data recovery
  // ----------------------------------------
  rx_state_e   state_reg, state_next;
  logic [4:0]  samp_reg, samp_next;
  logic [1:0]  vote_reg, vote_next;
  logic [3:0]  bitn_reg, bitn_next;
  logic [7:0]  shift_reg, shift_next;
  logic        par_reg, par_next;
  logic        prev_high_reg, prev_high_next;
  logic        hold_reg, hold_next;
  logic [4:0]  samp_per_bit;
  logic [4:0]  vote_first;
  logic        in_vote;
  logic        decide;
  logic        maj;
  logic [3:0]  nbits;
  logic [7:0]  data_al;
  logic        par_calc;
  logic        push;
  logic [ENTRY_W-1:0] push_data;
  logic        pm_on;

  assign pm_on        = serial_control_c_reg[CTRLC_PM_H];
  assign samp_per_bit = double_speed_select_reg ? SAMP_DS : SAMP_NORM;
  assign vote_first   = double_speed_select_reg ? VOTE_DS : VOTE_NORM;
  assign in_vote      = (samp_reg >= vote_first) && (samp_reg <= vote_first + VOTE_SPAN);
  assign decide       = tick && (samp_reg == vote_first + VOTE_SPAN);
  // two of three centre samples settle the bit
  assign maj = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & serial_in_pin)
             | (vote_reg[0] & serial_in_pin);
  assign nbits = 4'h5 + {2'b00, serial_control_c_reg[CTRLC_CS_H:CTRLC_CS_L]};

  always_comb begin
    unique case (serial_control_c_reg[CTRLC_CS_H:CTRLC_CS_L])
      2'h0:    data_al = {3'h0, shift_reg[7:3]};
      2'h1:    data_al = {2'h0, shift_reg[7:2]};
      2'h2:    data_al = {1'h0, shift_reg[7:1]};
      default: data_al = shift_reg;
    endcase
  end

  // odd parity inverts the even sum
  assign par_calc = (^data_al) ^ serial_control_c_reg[CTRLC_PM_L];
  assign push_data = {pm_on && (par_calc != par_reg), !maj, data_al};

  always_comb begin
    state_next     = state_reg;
    samp_next      = samp_reg;
    vote_next      = vote_reg;
    bitn_next      = bitn_reg;
    shift_next     = shift_reg;
    par_next       = par_reg;
    prev_high_next = prev_high_reg;
    hold_next      = hold_reg;
    push           = 1'b0;
    if (tick && state_reg != ST_IDLE) begin
      samp_next = (samp_reg == samp_per_bit) ? 5'h01 : samp_reg + 5'h01;
      if (in_vote) begin
        vote_next = {vote_reg[0], serial_in_pin};
      end
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (tick) begin
          prev_high_next = serial_in_pin;
          // late start acceptance in double speed
          if (hold_reg) begin
            hold_next = 1'b0;
          end else if (prev_high_reg && !serial_in_pin) begin
            samp_next  = 5'h02;
            state_next = ST_START;
          end
        end
      end
      ST_START: begin
        if (decide) begin
          if (maj) begin
            state_next     = ST_IDLE;
            prev_high_next = serial_in_pin;
          end else begin
            state_next = ST_BITS;
            bitn_next  = 4'h0;
          end
        end
      end
      ST_BITS: begin
        if (decide) begin
          shift_next = {maj, shift_reg[7:1]};
          bitn_next  = bitn_reg + 4'h1;
          if (bitn_reg == nbits - 4'h1) begin
            state_next = pm_on ? ST_PAR : ST_STOP;
          end
        end
      end
      ST_PAR: begin
        if (decide) begin
          par_next   = maj;
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (decide) begin
          push           = 1'b1;
          state_next     = ST_IDLE;
          prev_high_next = serial_in_pin;
          hold_next      = double_speed_select_reg;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!receiver_enable_reg) begin
      state_next     = ST_IDLE;
      prev_high_next = 1'b0;
      hold_next      = 1'b0;
      push           = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= ST_IDLE;
      samp_reg      <= 5'h00;
      vote_reg      <= 2'h0;
      bitn_reg      <= 4'h0;
      shift_reg     <= 8'h00;
      par_reg       <= 1'b0;
      prev_high_reg <= 1'b0;
      hold_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      samp_reg      <= samp_next;
      vote_reg      <= vote_next;
      bitn_reg      <= bitn_next;
      shift_reg     <= shift_next;
      par_reg       <= par_next;
      prev_high_reg <= prev_high_next;
      hold_reg      <= hold_next;
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  rx_buffer u_buf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (!receiver_enable_reg),
    .push      (push),
    .push_data (push_data),
    .pop       (rd_pop),
    .head      (head),
    .not_empty (head_valid)
  );

endmodule : serial_rx
`default_nettype wire

// ---- tb/serial_rx_chk.sv ----
// port assertions for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module serial_rx_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        serial_in_pin,
  input wire logic        serial_pin_owned
);
  import rx_pkg::*;
  logic       req, rd_stat, wr_ctlb;
  logic [7:0] wa_reg, wa_next;
  logic       pm_reg, pm_next, ds_reg, ds_next, low_reg, low_next;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign req     = hsel && hready && htrans[1];
  assign rd_stat = req && !hwrite && haddr[7:0] == ADDR_STAT;
  assign wr_ctlb = req && hwrite && haddr[7:0] == ADDR_CTRLB;
  // shadows taken from bus writes; data lands one cycle after its address
  always_comb begin
    wa_next  = (req && hwrite) ? haddr[7:0] : 8'hFF;
    pm_next  = (wa_reg == ADDR_CTRLC) ? hwdata[CTRLC_PM_H] : pm_reg;
    ds_next  = (wa_reg == ADDR_STAT) ? hwdata[STAT_DS] : ds_reg;
    low_next = serial_pin_owned && (low_reg || !serial_in_pin);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_reg  <= 8'hFF;
      pm_reg  <= CTRLC_RST[CTRLC_PM_H];
      ds_reg  <= 1'b0;
      low_reg <= 1'b0;
    end else begin
      wa_reg  <= wa_next;
      pm_reg  <= pm_next;
      ds_reg  <= ds_next;
      low_reg <= low_next;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_enable_pin: assert property (
    wr_ctlb |=> ##1 serial_pin_owned == $past(hwdata[CTRLB_EN]))
    else $error("pin ownership does not follow the enable write");
  chk_owned_cause: assert property (
    $changed(serial_pin_owned) |-> $past(wr_ctlb, 2))
    else $error("pin ownership changed without an enable write");
  chk_flush_status: assert property (
    rd_stat && !serial_pin_owned && !$past(serial_pin_owned)
    |=> !hrdata[STAT_RXC] && !hrdata[STAT_FE] && !hrdata[STAT_PE])
    else $error("status shows a character while disabled");
  chk_parity_off: assert property (
    rd_stat && !pm_reg |=> !hrdata[STAT_PE])
    else $error("parity flag set with checking off");
  chk_ds_read: assert property (
    rd_stat |=> hrdata[STAT_DS] == $past(ds_reg))
    else $error("double speed bit reads wrong");
  chk_flags_head: assert property (
    rd_stat |=> hrdata[STAT_RXC] || !(hrdata[STAT_FE] || hrdata[STAT_PE]))
    else $error("error flag without a buffered character");
  chk_quiet_line: assert property (
    rd_stat && !low_reg |=> !hrdata[STAT_RXC])
    else $error("character appeared on a line that never went low");
  chk_zero_wait: assert property (
    req |=> hreadyout && !hresp)
    else $error("bus transfer stalled or refused");
endmodule : serial_rx_chk
bind serial_rx serial_rx_chk u_chk (
  .hclk            (hclk),
  .hresetn         (hresetn),
  .hsel            (hsel),
  .haddr           (haddr),
  .htrans          (htrans),
  .hwrite          (hwrite),
  .hwdata          (hwdata),
  .hready          (hready),
  .hrdata          (hrdata),
  .hreadyout       (hreadyout),
  .hresp           (hresp),
  .serial_in_pin   (serial_in_pin),
  .serial_pin_owned(serial_pin_owned)
);
`default_nettype wire

// ---- tb/serial_tx_model.sv ----
// behavioural remote transmitter on the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
  input  wire logic hclk,
  output var logic  line
);
  // idle high; never left floating between frames
  initial line = 1'b1;
  // start, lsb-first data, optional parity, one stop; each bit held spb clocks, the stop bit spb - cut
  task automatic send(input logic [7:0] d, input int nd, input logic pen, input logic p,
                      input logic stop, input int spb, input int cut = 0);
    logic [10:0] f;
    int          n;
    f = {2'b11, d, 1'b0};
    n = nd + 1;
    if (pen) begin
      f[n] = p;
      n++;
    end
    f[n] = stop;
    for (int i = 0; i <= n; i++) begin
      line <= f[i]; // exact rate, no drift
      // a cut stop bit lets the next start follow the stop vote at once
      repeat ((i == n) ? spb - cut : spb) @(posedge hclk);
    end
    if (!stop) begin
      line <= 1'b1;
    end
  endtask : send
  // low spike of k clocks, only when a test asks for noise
  task automatic glitch(input int k);
    line <= 1'b0;
    repeat (k) @(posedge hclk);
    line <= 1'b1;
  endtask : glitch
endmodule : serial_tx_model
`default_nettype wire

// ---- tb/async_serial_receiver_recovery_tb_top.sv ----
// self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver_recovery_tb_top;
  import rx_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, rx_line, owned;
  int          fail_count = 0;
  int          checks_done = 0;
  always #5 hclk = ~hclk;
  serial_rx u_dut (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (3'h2),
    .hwdata          (hwdata),
    .hready          (hreadyout),
    .hrdata          (hrdata),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .serial_in_pin   (rx_line),
    .serial_pin_owned(owned)
  );
  serial_tx_model u_tx (
    .hclk(hclk),
    .line(rx_line)
  );
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // bounded wait: a stuck slave ends the run instead of hanging it
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer
  task automatic expect_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : expect_eq
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    expect_eq(what, exp, x);
  endtask : rd
  function automatic logic [31:0] st(input logic c, f, p, d);
    st = 32'h0;
    st[STAT_RXC] = c;
    st[STAT_FE] = f;
    st[STAT_PE] = p;
    st[STAT_DS] = d;
  endfunction : st
  // status first, then data: flags describe the head character
  task automatic got_char(input string what, input logic [7:0] d, input logic fe, pe, ds);
    rd(what, ADDR_STAT, st(1'b1, fe, pe, ds));
    rd(what, ADDR_DATA, {24'h0, d});
  endtask : got_char
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("ctrl_c", ADDR_CTRLC, {24'h0, CTRLC_RST});
    rd("baud", ADDR_BAUD, {20'h0, BAUD_RST});
    rd("status", ADDR_STAT, 32'h0);
    rd("unmapped", 8'h14, 32'h0);
    wr(ADDR_CTRLB, 32'h10);
    @(posedge hclk);
    expect_eq("owned", 32'h1, {31'h0, owned});
    $display("test reset_enable done");
    for (int ds = 0; ds < 2; ds++) begin
      d = ds ? 8'h5A : 8'hA5;
      wr(ADDR_STAT, {30'h0, ds[0], 1'b0});
      u_tx.glitch(8 >> ds);
      repeat (40) @(posedge hclk);
      rd("noise", ADDR_STAT, st(1'b0, 1'b0, 1'b0, ds[0]));
      u_tx.send(d, 8, 1'b0, 1'b0, 1'b1, 16 >> ds);
      got_char("speed", d, 1'b0, 1'b0, ds[0]);
    end
    wr(ADDR_STAT, 32'h0);
    $display("test speed_noise done");
    for (int m = 0; m < 4; m++) begin
      d = 8'h3C ^ 8'(m);
      wr(ADDR_CTRLC, {26'h0, 1'b1, m[1], 4'h6});
      u_tx.send(d, 8, 1'b1, (^d) ^ m[1] ^ m[0], 1'b1, 16);
      got_char("parity", d, 1'b0, m[0], 1'b0);
    end
    wr(ADDR_CTRLC, 32'h06);
    u_tx.send(8'h81, 8, 1'b0, 1'b0, 1'b1, 16);
    got_char("parity off", 8'h81, 1'b0, 1'b0, 1'b0);
    $display("test parity done");
    wr(ADDR_CTRLC, 32'h26);
    u_tx.send(8'h01, 8, 1'b1, 1'b0, 1'b1, 16, 6);
    u_tx.send(8'h02, 8, 1'b1, 1'b1, 1'b1, 16);
    u_tx.send(8'h03, 8, 1'b1, 1'b0, 1'b1, 16);
    wr(ADDR_CTRLC, 32'h06);
    rd("parity masked", ADDR_STAT, st(1'b1, 1'b0, 1'b0, 1'b0));
    wr(ADDR_CTRLC, 32'h26);
    got_char("head", 8'h01, 1'b0, 1'b1, 1'b0);
    got_char("second", 8'h02, 1'b0, 1'b0, 1'b0);
    rd("drained", ADDR_STAT, 32'h0);
    $display("test buffer done");
    wr(ADDR_CTRLC, 32'h0);
    u_tx.send(8'hF3, 5, 1'b0, 1'b0, 1'b0, 16);
    got_char("framing", 8'h13, 1'b1, 1'b0, 1'b0);
    for (int c = 1; c < 3; c++) begin
      wr(ADDR_CTRLC, {29'h0, 2'(c), 1'b0});
      u_tx.send(8'hD6, 5 + c, 1'b0, 1'b0, 1'b1, 16);
      got_char("size", 8'hD6 & (8'hFF >> (3 - c)), 1'b0, 1'b0, 1'b0);
    end
    $display("test framing done");
    wr(ADDR_CTRLC, 32'h06);
    u_tx.send(8'h11, 8, 1'b0, 1'b0, 1'b1, 16);
    fork
      u_tx.send(8'h22, 8, 1'b0, 1'b0, 1'b1, 16);
      begin
        repeat (60) @(posedge hclk);
        wr(ADDR_CTRLB, 32'h0);
      end
    join
    expect_eq("released", 32'h0, {31'h0, owned});
    rd("flushed", ADDR_STAT, 32'h0);
    wr(ADDR_CTRLB, 32'h10);
    repeat (2) @(posedge hclk);
    u_tx.send(8'h33, 8, 1'b0, 1'b0, 1'b1, 16);
    got_char("after abort", 8'h33, 1'b0, 1'b0, 1'b0);
    $display("test disable done");
    stop_test();
  end
endmodule : async_serial_receiver_recovery_tb_top
`default_nettype wire
